// file: design/ddrca_front.sv
// Purpose: command, address and clock-gate front end of a ddr3 memory
// Assumes: core_clk rising edge is the true-rising crossing of the pair
// Notes: each clock cycle carries two data beats, rise half then fall half

// Behaviour
// - capture all inputs on true-rising crossing
// - read beats on both clock crossings
// - gate low freezes state from next cycle
// - gate low, banks idle: power-down or self-refresh
// - bank lines route command to one bank
// - bank-open latches thirteen row lines
// - read/write takes ten column lines plus options
// - mode write loads address as op code
// - burst of four or eight beats
// - sequential or interleaved beat order
// - additive latency zero, cl-1 or cl-2
// - strobe driven by memory reads, controller writes
// - eight banks open or idle independently
// - chip select high masks every command
// - strobe levels decode open, precharge, read, write
// - line 10 selects auto or all-bank precharge
// - line 12 low chops the burst
module ddrca_front
(
  // clock and reset
  input wire logic core_clk,
  input wire logic rst_b,
  // avalon-mm register slave
  input wire logic [4:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic [3:0] avs_byteenable,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  // command and address pins
  input wire logic cke,
  input wire logic cs_b,
  input wire logic ras_b,
  input wire logic cas_b,
  input wire logic we_b,
  input wire logic [ddrca_pkg::BA_W-1:0] bank_select_lines,
  input wire logic [ddrca_pkg::ROW_W-1:0] address_lines,
  // data pins, split into rise and fall halves
  input wire logic [ddrca_pkg::DQ_W-1:0] dq_rise_i,
  input wire logic [ddrca_pkg::DQ_W-1:0] dq_fall_i,
  input wire logic dqs_i,
  output logic [ddrca_pkg::DQ_W-1:0] dq_rise_o,
  output logic [ddrca_pkg::DQ_W-1:0] dq_fall_o,
  output logic dq_oe,
  output logic dqs_o,
  output logic dqs_oe,
  // cell array port
  output logic arr_req,
  output logic arr_we,
  output logic [ddrca_pkg::BA_W-1:0] arr_bank,
  output logic [ddrca_pkg::ROW_W-1:0] arr_row,
  output logic [ddrca_pkg::COL_W-1:0] arr_col_a,
  output logic [ddrca_pkg::COL_W-1:0] arr_col_b,
  output logic [31:0] arr_wdata,
  input wire logic [31:0] arr_rdata
);
  import ddrca_pkg::*;

  // gate sampled at the last edge
  logic cke_ff;
  // internal clock runs this cycle
  logic run;
  // command from pins before and after masking
  ddrca_cmd_e cmd_raw;
  ddrca_cmd_e cmd;
  // mode registers
  logic [ROW_W-1:0] mr_ff [4];
  // bank state
  logic [NBANK-1:0] open_ff;
  logic [ROW_W-1:0] row_ff [NBANK];
  // burst engine state
  ddrca_phase_e phase_ff;
  logic [4:0] lat_cnt_ff;
  logic [1:0] beat_ff;
  logic bst_we_ff;
  logic bst_bt_ff;
  logic bst_len4_ff;
  logic bst_ap_ff;
  logic [BA_W-1:0] bst_bank_ff;
  logic [COL_W-1:0] bst_col_ff;
  // derived burst terms
  logic [4:0] lat;
  logic start;
  logic bad;
  logic last;
  logic bst_end;
  // power state and status
  ddrca_pwr_e pwr_ff;
  logic err_ff;
  logic [15:0] ref_cnt_ff;
  // read drive flag for dq and strobe
  logic drv_ff;
  // bus handshake
  logic ack_ff;
  logic [31:0] rdata_ff;
  logic bus_wr;
  logic [31:0] stat;

  // beat column for beat i of a burst starting at c
  function automatic logic [COL_W-1:0] burst_col(
    input logic [COL_W-1:0] c,
    input logic [2:0] i,
    input logic il,
    input logic b4
  );
    logic [2:0] lo;
    lo = il ? (c[2:0] ^ i) : (c[2:0] + i);
    // a chopped burst wraps inside its four-column half
    if (b4)
    begin
      lo[2] = c[2];
    end
    return {c[COL_W-1:3], lo};
  endfunction

  // byte-lane merge of a bus write into a mode register
  function automatic logic [ROW_W-1:0] be_merge(
    input logic [ROW_W-1:0] old,
    input logic [31:0] wd,
    input logic [3:0] be
  );
    logic [ROW_W-1:0] r;
    r = old;
    if (be[0])
    begin
      r[7:0] = wd[7:0];
    end
    if (be[1])
    begin
      r[ROW_W-1:8] = wd[ROW_W-1:8];
    end
    return r;
  endfunction

  // gate capture; everything is sampled on the rising edge only
  always_ff @(posedge core_clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      cke_ff <= 1'b0;
    end
    else
    begin
      cke_ff <= cke;
    end
  end

  // low gate at the last edge suspends the internal clock now
  assign run = cke_ff;

  // strobe decode, chip select is part of the code
  always_comb
  begin
    case ({cs_b, ras_b, cas_b, we_b})
      4'b0011: cmd_raw = CMD_OPEN;
      4'b0010: cmd_raw = CMD_PRE;
      4'b0101: cmd_raw = CMD_RD;
      4'b0100: cmd_raw = CMD_WR;
      4'b0000: cmd_raw = CMD_MRS;
      4'b0001: cmd_raw = CMD_REF;
      default: cmd_raw = CMD_NOP;
    endcase
  end

  // commands count only with the gate high at this and the last edge
  assign cmd = (run && cke && pwr_ff == PW_NORM) ? cmd_raw : CMD_NOP;

  // total read latency; a zero setting is held at one cycle
  always_comb
  begin
    logic [4:0] cl;
    logic [4:0] al;
    cl = {1'b0, mr_ff[0][MR0_CL_LSB +: CL_W]};
    al = 5'd0;
    case (mr_ff[1][MR1_AL_LSB +: AL_W])
      AL_CLM1: al = (cl > 5'd1) ? cl - 5'd1 : 5'd0;
      AL_CLM2: al = (cl > 5'd2) ? cl - 5'd2 : 5'd0;
      default: al = 5'd0;
    endcase
    lat = cl + al;
    if (lat == 5'd0)
    begin
      lat = 5'd1;
    end
  end

  // a burst may start only into an open bank with the engine idle
  assign start = (cmd == CMD_RD || cmd == CMD_WR) &&
                 open_ff[bank_select_lines] && phase_ff == PH_IDLE;
  // refused commands: access to an idle bank, overlap, reopening
  assign bad = ((cmd == CMD_RD || cmd == CMD_WR) && !start) ||
               (cmd == CMD_OPEN && open_ff[bank_select_lines]);
  assign last = beat_ff == (bst_len4_ff ? 2'd1 : 2'd3);
  assign bst_end = run && phase_ff == PH_BURST && last;

  // burst engine: latency wait, then two beats per cycle
  always_ff @(posedge core_clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      phase_ff <= PH_IDLE;
      lat_cnt_ff <= 5'd0;
      beat_ff <= 2'd0;
      bst_we_ff <= 1'b0;
      bst_bt_ff <= 1'b0;
      bst_len4_ff <= 1'b0;
      bst_ap_ff <= 1'b0;
      bst_bank_ff <= '0;
      bst_col_ff <= '0;
    end
    else if (run)
    begin
      case (phase_ff)
        PH_IDLE:
        begin
          if (start)
          begin
            bst_we_ff <= cmd == CMD_WR;
            bst_bank_ff <= bank_select_lines;
            bst_col_ff <= address_lines[COL_W-1:0];
            bst_ap_ff <= address_lines[AP_BIT];
            // fixed four, or chopped on the fly by a low line 12
            bst_len4_ff <= mr_ff[0][MR0_BL4_BIT] ||
                           !address_lines[BC_BIT];
            bst_bt_ff <= mr_ff[0][MR0_BT_BIT];
            beat_ff <= 2'd0;
            lat_cnt_ff <= lat - 5'd1;
            phase_ff <= (lat == 5'd1) ? PH_BURST : PH_WAIT;
          end
        end
        PH_WAIT:
        begin
          lat_cnt_ff <= lat_cnt_ff - 5'd1;
          if (lat_cnt_ff == 5'd1)
          begin
            phase_ff <= PH_BURST;
          end
        end
        PH_BURST:
        begin
          beat_ff <= beat_ff + 2'd1;
          if (last)
          begin
            phase_ff <= PH_IDLE;
          end
        end
        default: phase_ff <= PH_IDLE;
      endcase
    end
  end

  // bank table; auto precharge closes first so a new open still wins
  always_ff @(posedge core_clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      open_ff <= '0;
      for (int b = 0; b < NBANK; b++)
      begin
        row_ff[b] <= '0;
      end
    end
    else
    begin
      if (bst_end && bst_ap_ff)
      begin
        open_ff[bst_bank_ff] <= 1'b0;
      end
      if (cmd == CMD_PRE)
      begin
        // line 10 high closes every bank, low only the selected one
        if (address_lines[AP_BIT])
        begin
          open_ff <= '0;
        end
        else
        begin
          open_ff[bank_select_lines] <= 1'b0;
        end
      end
      if (cmd == CMD_OPEN && !open_ff[bank_select_lines])
      begin
        open_ff[bank_select_lines] <= 1'b1;
        row_ff[bank_select_lines] <= address_lines;
      end
    end
  end

  // mode registers; a pin mode write beats a bus write in the same cycle
  always_ff @(posedge core_clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      mr_ff[0] <= MR0_RST;
      mr_ff[1] <= MRX_RST;
      mr_ff[2] <= MRX_RST;
      mr_ff[3] <= MRX_RST;
    end
    else if (cmd == CMD_MRS && !bank_select_lines[BA_W-1])
    begin
      mr_ff[bank_select_lines[1:0]] <= address_lines;
    end
    else if (bus_wr && avs_address[4] == 1'b0)
    begin
      mr_ff[avs_address[3:2]] <= be_merge(mr_ff[avs_address[3:2]],
                                          avs_writedata, avs_byteenable);
    end
  end

  // power state: entry needs idle banks, refresh on entry picks self
  always_ff @(posedge core_clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      pwr_ff <= PW_NORM;
    end
    else if (pwr_ff != PW_NORM)
    begin
      if (cke)
      begin
        pwr_ff <= PW_NORM;
      end
    end
    else if (cke_ff && !cke && open_ff == '0 && phase_ff == PH_IDLE)
    begin
      pwr_ff <= (cmd_raw == CMD_REF) ? PW_SELF : PW_PDN;
    end
  end

  // refresh counter; refresh is only legal with every bank idle
  always_ff @(posedge core_clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      ref_cnt_ff <= 16'h0000;
    end
    else if (cmd == CMD_REF && open_ff == '0)
    begin
      ref_cnt_ff <= ref_cnt_ff + 16'h0001;
    end
  end

  // sticky refusal flag; a new refusal outranks the software clear
  always_ff @(posedge core_clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      err_ff <= 1'b0;
    end
    else if (bad)
    begin
      err_ff <= 1'b1;
    end
    else if (bus_wr && avs_address == OFS_STAT && avs_byteenable[1] &&
             avs_writedata[ST_ERR_BIT])
    begin
      err_ff <= 1'b0;
    end
  end

  // array access: two columns per cycle, one per clock crossing
  assign arr_bank = bst_bank_ff;
  assign arr_row = row_ff[bst_bank_ff];
  assign arr_col_a = burst_col(bst_col_ff, {beat_ff, 1'b0},
                               bst_bt_ff, bst_len4_ff);
  assign arr_col_b = burst_col(bst_col_ff, {beat_ff, 1'b1},
                               bst_bt_ff, bst_len4_ff);
  // write beats count only while the controller's strobe runs
  assign arr_req = run && phase_ff == PH_BURST && (!bst_we_ff || dqs_i);
  assign arr_we = arr_req && bst_we_ff;
  assign arr_wdata = {dq_fall_i, dq_rise_i};

  // read output: rise half and fall half from flops, frozen with the gate
  always_ff @(posedge core_clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      dq_rise_o <= '0;
      dq_fall_o <= '0;
      drv_ff <= 1'b0;
    end
    else if (run)
    begin
      if (phase_ff == PH_BURST && !bst_we_ff)
      begin
        dq_rise_o <= arr_rdata[DQ_W-1:0];
        dq_fall_o <= arr_rdata[31:DQ_W];
        drv_ff <= 1'b1;
      end
      else
      begin
        drv_ff <= 1'b0;
      end
    end
  end

  // memory drives dq and strobe only during read beats
  assign dq_oe = drv_ff;
  assign dqs_oe = drv_ff;
  assign dqs_o = drv_ff;

  // status word
  always_comb
  begin
    stat = 32'h0000_0000;
    stat[ST_OPEN_LSB +: NBANK] = open_ff;
    stat[ST_PWR_LSB +: 2] = pwr_ff;
    stat[ST_BUSY_BIT] = phase_ff != PH_IDLE;
    stat[ST_ERR_BIT] = err_ff;
    stat[ST_CKE_BIT] = cke_ff;
    stat[ST_REF_LSB +: 16] = ref_cnt_ff;
  end

  // bus: one wait cycle, then the access is taken with waitrequest low
  assign avs_waitrequest = (avs_read || avs_write) && !ack_ff;
  assign bus_wr = avs_write && ack_ff;
  assign avs_readdata = rdata_ff;

  // handshake flop and read data, loaded in the wait cycle
  always_ff @(posedge core_clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      ack_ff <= 1'b0;
      rdata_ff <= 32'h0000_0000;
    end
    else
    begin
      ack_ff <= (avs_read || avs_write) && !ack_ff;
      if (avs_read && !ack_ff)
      begin
        // unmapped offsets read as zero
        if (avs_address[4] == 1'b0 && avs_address[1:0] == 2'b00)
        begin
          rdata_ff <= {19'h0_0000, mr_ff[avs_address[3:2]]};
        end
        else if (avs_address == OFS_STAT)
        begin
          rdata_ff <= stat;
        end
        else
        begin
          rdata_ff <= 32'h0000_0000;
        end
      end
    end
  end
endmodule // ddrca_front

// file: design/ddrca_pkg.sv
// Purpose: shared constants and types of the command/address front end
// Assumes: one 50 MHz clock stands in for the memory's true clock
// Notes: register offsets are byte addresses on the avalon slave
package ddrca_pkg;
  // array geometry
  localparam int NBANK = 8;
  localparam int BA_W = 3;
  localparam int ROW_W = 13;
  localparam int COL_W = 10;
  localparam int DQ_W = 16;
  // address lines with extra meaning
  localparam int AP_BIT = 10;
  localparam int BC_BIT = 12;
  // clock rate, used for nothing but documenting cycle counts
  localparam int CLK_HZ = 50_000_000;
  // avalon register byte offsets
  localparam logic [4:0] OFS_MR0 = 5'h00;
  localparam logic [4:0] OFS_MR1 = 5'h04;
  localparam logic [4:0] OFS_MR2 = 5'h08;
  localparam logic [4:0] OFS_MR3 = 5'h0C;
  localparam logic [4:0] OFS_STAT = 5'h10;
  // mode register fields
  localparam int MR0_BL4_BIT = 0;
  localparam int MR0_BT_BIT = 3;
  localparam int MR0_CL_LSB = 4;
  localparam int CL_W = 4;
  localparam int MR1_AL_LSB = 3;
  localparam int AL_W = 2;
  // additive latency codes
  localparam logic [1:0] AL_ZERO = 2'h0;
  localparam logic [1:0] AL_CLM1 = 2'h1;
  localparam logic [1:0] AL_CLM2 = 2'h2;
  // reset values: burst 8, sequential, read latency 5, no additive
  localparam logic [ROW_W-1:0] MR0_RST = 13'h0050;
  localparam logic [ROW_W-1:0] MRX_RST = 13'h0000;
  // status word fields
  localparam int ST_OPEN_LSB = 0;
  localparam int ST_PWR_LSB = 8;
  localparam int ST_BUSY_BIT = 10;
  localparam int ST_ERR_BIT = 11;
  localparam int ST_CKE_BIT = 12;
  localparam int ST_REF_LSB = 16;
  // burst phases, gray along idle-wait-burst
  typedef enum logic [1:0] {
    PH_IDLE = 2'b00,
    PH_WAIT = 2'b01,
    PH_BURST = 2'b11
  } ddrca_phase_e;
  // power state
  typedef enum logic [1:0] {
    PW_NORM = 2'b00,
    PW_PDN = 2'b01,
    PW_SELF = 2'b11
  } ddrca_pwr_e;
  // decoded commands
  typedef enum logic [2:0] {
    CMD_NOP = 3'h0,
    CMD_OPEN = 3'h1,
    CMD_PRE = 3'h2,
    CMD_RD = 3'h3,
    CMD_WR = 3'h4,
    CMD_MRS = 3'h5,
    CMD_REF = 3'h6
  } ddrca_cmd_e;
endpackage

// file: verif/ddrca_front_asserts.sv
// Purpose: port checks of the command front end
// Assumes: one clock, rst_b active low
// Notes: bind follows the module
module ddrca_front_asserts
(
  // clock and reset
  input wire logic core_clk,
  input wire logic rst_b,
  // register slave
  input wire logic [4:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_readdata,
  input wire logic avs_waitrequest,
  // pins and array port
  input wire logic cke,
  input wire logic [ddrca_pkg::DQ_W-1:0] dq_rise_i,
  input wire logic [ddrca_pkg::DQ_W-1:0] dq_fall_i,
  input wire logic [ddrca_pkg::DQ_W-1:0] dq_rise_o,
  input wire logic [ddrca_pkg::DQ_W-1:0] dq_fall_o,
  input wire logic dq_oe,
  input wire logic dqs_o,
  input wire logic dqs_oe,
  input wire logic arr_req,
  input wire logic arr_we,
  input wire logic [31:0] arr_wdata,
  input wire logic [31:0] arr_rdata
);
  timeunit 1ns;
  timeprecision 1ps;
  import ddrca_pkg::*;
  // cke of the last edge; low means this edge is frozen
  logic cke_q_ff;
  always_ff @(posedge core_clk or negedge rst_b)
  begin
    if (!rst_b)
      cke_q_ff <= 1'b0;
    else
      cke_q_ff <= cke;
  end
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!rst_b);
  wait_one_a: assert property ($rose(avs_read || avs_write) |->
    avs_waitrequest ##1 !avs_waitrequest) else $error("bus wait");
  ack_once_a: assert property ((avs_read || avs_write) &&
    !avs_waitrequest |=> !(avs_read || avs_write) || avs_waitrequest)
    else $error("bus ack");
  hole_zero_a: assert property (avs_read && !avs_waitrequest &&
    avs_address > 5'h10 |-> avs_readdata == 32'h0000_0000)
    else $error("hole data");
  oe_tie_a: assert property (dqs_oe == dq_oe && dqs_o == dq_oe)
    else $error("oe split");
  // a running edge must load the read beats into dq_rise_o and dq_fall_o
  read_path_a: assert property (arr_req && !arr_we && cke_q_ff |=>
    dq_oe && dq_rise_o == $past(arr_rdata[15:0]) &&
    dq_fall_o == $past(arr_rdata[31:16])) else $error("read beat");
  write_path_a: assert property (arr_we |-> arr_req &&
    arr_wdata == {dq_fall_i, dq_rise_i}) else $error("write beat");
  burst_min_a: assert property ($rose(dq_oe) |-> dq_oe[*2])
    else $error("burst short");
  freeze_out_a: assert property (!cke |-> ##2 $stable(dq_oe) &&
    $stable(dq_rise_o) && $stable(dq_fall_o)) else $error("freeze");
  oe_end_a: assert property ($fell(dq_oe) |->
    !$past(arr_req) || $past(arr_we)) else $error("oe drop");
  cover property ($rose(dq_oe));
  cover property (arr_we);
  cover property (!cke && !cke_q_ff);
endmodule // ddrca_front_asserts

bind ddrca_front ddrca_front_asserts u_chk (
  .core_clk(core_clk), .rst_b(rst_b), .avs_address(avs_address),
  .avs_read(avs_read), .avs_write(avs_write),
  .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
  .cke(cke), .dq_rise_i(dq_rise_i), .dq_fall_i(dq_fall_i),
  .dq_rise_o(dq_rise_o), .dq_fall_o(dq_fall_o), .dq_oe(dq_oe),
  .dqs_o(dqs_o), .dqs_oe(dqs_oe), .arr_req(arr_req), .arr_we(arr_we),
  .arr_wdata(arr_wdata), .arr_rdata(arr_rdata)
);

// file: verif/ddrca_array_model.sv
// Purpose: behavioural cell array behind the front end
// Assumes: read answer is combinational while arr_req is high
// Notes: idle cycles show a moving pattern, so stale data never matches
module ddrca_array_model
(
  // clock
  input wire logic core_clk,
  // array port
  input wire logic arr_req,
  input wire logic arr_we,
  input wire logic [ddrca_pkg::BA_W-1:0] arr_bank,
  input wire logic [ddrca_pkg::ROW_W-1:0] arr_row,
  input wire logic [ddrca_pkg::COL_W-1:0] arr_col_a,
  input wire logic [ddrca_pkg::COL_W-1:0] arr_col_b,
  input wire logic [31:0] arr_wdata,
  output logic [31:0] arr_rdata
);
  timeunit 1ns;
  timeprecision 1ps;
  import ddrca_pkg::*;
  logic [15:0] mem [0:63]; // per bank, low column bits only
  logic [15:0] spin_ff; // idle filler
  logic [15:0] rx; // row folded into data, so a wrong row shows
  assign rx = 16'(arr_row);
  initial
  begin
    spin_ff = 16'h0001;
    for (int i = 0; i < 64; i++)
      mem[i] = 16'h5A00 + 16'(i);
  end
  // each bank keeps its own cells
  always @(posedge core_clk)
  begin
    spin_ff <= spin_ff + 16'h1357;
    if (arr_req && arr_we)
    begin
      mem[{arr_bank, arr_col_a[2:0]}] <= arr_wdata[15:0] ^ rx;
      mem[{arr_bank, arr_col_b[2:0]}] <= arr_wdata[31:16] ^ rx;
    end
  end
  assign arr_rdata = (arr_req && !arr_we) ?
    {mem[{arr_bank, arr_col_b[2:0]}] ^ rx,
     mem[{arr_bank, arr_col_a[2:0]}] ^ rx} : {spin_ff, ~spin_ff};
endmodule // ddrca_array_model

// file: verif/ddrca_front_tb.sv
// Purpose: self-checking bench of the command front end
// Assumes: 50 MHz core_clk, pins driven by nonblocking at rising edge
// Notes: sh mirrors the array model contents
module ddrca_front_tb;
  timeunit 1ns;
  timeprecision 1ps;
  import ddrca_pkg::*;
  logic core_clk, rst_b, avs_read, avs_write, avs_waitrequest;
  logic [4:0] avs_address;
  logic [31:0] avs_writedata, avs_readdata, arr_wdata, arr_rdata;
  logic [3:0] avs_byteenable;
  logic cke, cs_b, ras_b, cas_b, we_b, dqs_i, dq_oe, dqs_o, dqs_oe;
  logic arr_req, arr_we;
  logic [BA_W-1:0] bank_select_lines, arr_bank;
  logic [ROW_W-1:0] address_lines, arr_row;
  logic [COL_W-1:0] arr_col_a, arr_col_b;
  logic [DQ_W-1:0] dq_rise_i, dq_fall_i, dq_rise_o, dq_fall_o;
  logic [15:0] sh [0:63];
  int n_fail = 0;
  int compares = 0;
  ddrca_front uut (
    .core_clk(core_clk), .rst_b(rst_b), .avs_address(avs_address),
    .avs_read(avs_read), .avs_write(avs_write),
    .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
    .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
    .cke(cke), .cs_b(cs_b), .ras_b(ras_b), .cas_b(cas_b), .we_b(we_b),
    .bank_select_lines(bank_select_lines), .address_lines(address_lines),
    .dq_rise_i(dq_rise_i), .dq_fall_i(dq_fall_i), .dqs_i(dqs_i),
    .dq_rise_o(dq_rise_o), .dq_fall_o(dq_fall_o), .dq_oe(dq_oe),
    .dqs_o(dqs_o), .dqs_oe(dqs_oe), .arr_req(arr_req), .arr_we(arr_we),
    .arr_bank(arr_bank), .arr_row(arr_row), .arr_col_a(arr_col_a),
    .arr_col_b(arr_col_b), .arr_wdata(arr_wdata), .arr_rdata(arr_rdata)
  );
  ddrca_array_model u_arr (
    .core_clk(core_clk), .arr_req(arr_req), .arr_we(arr_we),
    .arr_bank(arr_bank), .arr_row(arr_row), .arr_col_a(arr_col_a),
    .arr_col_b(arr_col_b), .arr_wdata(arr_wdata), .arr_rdata(arr_rdata)
  );
  initial
  begin
    core_clk = 1'b0;
    forever #10 core_clk = ~core_clk;
  end
  task automatic summarize;
    $display("compares %0d n_fail %0d", compares, n_fail);
    if (n_fail == 0 && compares > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [31:0] e,
    input logic [31:0] g);
    compares++;
    if (g !== e)
    begin
      n_fail++;
      $display("BAD %s expected %h seen %h", nm, e, g);
    end
  endtask
  // one avalon transfer; held until waitrequest is seen low
  task automatic bus(input logic w, input logic [4:0] a,
    input logic [31:0] d, output logic [31:0] q);
    logic wt;
    @(posedge core_clk);
    avs_address <= a;
    avs_writedata <= d;
    avs_write <= w;
    avs_read <= !w;
    wt = 1'b1;
    for (int n = 0; n < 20 && wt !== 1'b0; n++)
    begin
      #1;
      wt = avs_waitrequest;
      q = avs_readdata;
      @(posedge core_clk);
    end
    avs_read <= 1'b0;
    avs_write <= 1'b0;
    if (wt !== 1'b0)
    begin
      n_fail++;
      summarize();
    end
  endtask
  task automatic rchk(input string nm, input logic [4:0] a,
    input logic [31:0] e, input logic [31:0] m = 32'hFFFF_FFFF);
    logic [31:0] q;
    bus(1'b0, a, 32'h0000_0000, q);
    chk(nm, e, q & m);
  endtask
  task automatic wreg(input logic [4:0] a, input logic [31:0] d);
    logic [31:0] q;
    bus(1'b1, a, d, q);
  endtask
  // command pins for one edge, then cs_b high
  task automatic cmd(input logic [3:0] c, input logic [2:0] b,
    input logic [12:0] a);
    @(posedge core_clk);
    {cs_b, ras_b, cas_b, we_b} <= c;
    bank_select_lines <= b;
    address_lines <= a;
    @(posedge core_clk);
    {cs_b, ras_b, cas_b, we_b} <= 4'hF;
  endtask
  function automatic logic [2:0] bc(input logic [2:0] s, input int i,
    input logic il, input logic ch);
    logic [2:0] c;
    c = il ? s ^ 3'(i) : s + 3'(i);
    if (ch)
      c[2] = s[2];
    return c;
  endfunction
  task automatic rd(input logic [2:0] b, input logic [12:0] r,
    input logic [2:0] s, input logic ch, input logic il, input int l);
    int n;
    cmd(4'b0101, b, {!ch, 9'h000, s});
    for (n = 0; n < 40 && dq_oe !== 1'b1; n++)
    begin
      @(posedge core_clk);
      #1;
    end
    chk("latency", l, n);
    if (n == 40)
      summarize();
    for (int k = 0; k < (ch ? 2 : 4); k++)
    begin
      if (k > 0)
      begin
        @(posedge core_clk);
        #1;
      end
      chk("rise", sh[{b, bc(s, 2 * k, il, ch)}] ^ 16'(r), dq_rise_o);
      chk("fall", sh[{b, bc(s, 2 * k + 1, il, ch)}] ^ 16'(r), dq_fall_o);
    end
    @(posedge core_clk);
    #1;
    chk("oe off", 0, dq_oe);
  endtask
  // read burst with the gate low at one edge after the second pair
  task automatic frz(input logic [2:0] b, input logic [12:0] r,
    input logic [2:0] s, input int l);
    int n;
    int p;
    logic [15:0] e;
    cmd(4'b0101, b, {1'b1, 9'h000, s});
    for (n = 0; n < 40 && dq_oe !== 1'b1; n++)
    begin
      @(posedge core_clk);
      #1;
    end
    chk("frz latency", l, n);
    if (n == 40)
      summarize();
    // pairs seen: 0, 1, 2, 2 again while frozen, then 3
    for (int k = 0; k < 5; k++)
    begin
      if (k > 0)
      begin
        @(posedge core_clk);
        cke <= (k != 1);
        #1;
      end
      p = (k > 2) ? k - 1 : k;
      e = sh[{b, bc(s, 2 * p, 1'b1, 1'b0)}] ^ 16'(r);
      chk("frz rise", e, dq_rise_o);
      e = sh[{b, bc(s, 2 * p + 1, 1'b1, 1'b0)}] ^ 16'(r);
      chk("frz fall", e, dq_fall_o);
    end
    @(posedge core_clk);
    #1;
    chk("frz oe off", 0, dq_oe);
  endtask
  // chopped write, two beat pairs with the strobe running
  task automatic wr(input logic [2:0] b, input logic [12:0] r,
    input logic [2:0] s, input logic il, input int l);
    cmd(4'b0100, b, {1'b0, 9'h000, s});
    repeat (l - 1) @(posedge core_clk);
    for (int k = 0; k < 2; k++)
    begin
      dq_rise_i <= 16'hC300 + 16'(k);
      dq_fall_i <= 16'h0C70 + 16'(k);
      dqs_i <= 1'b1;
      sh[{b, bc(s, 2 * k, il, 1'b1)}] = (16'hC300 + 16'(k)) ^ 16'(r);
      sh[{b, bc(s, 2 * k + 1, il, 1'b1)}] = (16'h0C70 + 16'(k)) ^ 16'(r);
      @(posedge core_clk);
    end
    dqs_i <= 1'b0;
  endtask
  task automatic quiet;
    for (int k = 0; k < 12; k++)
    begin
      @(posedge core_clk);
      #1;
      chk("quiet", 0, dq_oe);
    end
  endtask
  // cke low with idle banks, then wake
  task automatic gate(input logic [3:0] c, input logic [15:0] e);
    @(posedge core_clk);
    cke <= 1'b0;
    {cs_b, ras_b, cas_b, we_b} <= c;
    @(posedge core_clk);
    {cs_b, ras_b, cas_b, we_b} <= 4'hF;
    rchk("power", OFS_STAT, {16'h0000, e}, 32'h0000_FFFF);
    cke <= 1'b1;
    repeat (3) @(posedge core_clk);
    rchk("wake", OFS_STAT, 32'h0000_1000, 32'h0000_FFFF);
  endtask
  initial
  begin
    {rst_b, avs_read, avs_write, dqs_i} = 4'h0;
    {avs_address, avs_writedata, bank_select_lines} = '0;
    {address_lines, dq_rise_i, dq_fall_i} = '0;
    avs_byteenable = 4'hF;
    cke = 1'b1;
    {cs_b, ras_b, cas_b, we_b} = 4'hF;
    for (int i = 0; i < 64; i++)
      sh[i] = 16'h5A00 + 16'(i);
    repeat (3) @(posedge core_clk);
    rst_b <= 1'b1;
    repeat (2) @(posedge core_clk);
    rchk("mr0", OFS_MR0, 32'h0000_0050);
    rchk("hole", 5'h14, 32'h0000_0000);
    wreg(OFS_MR2, 32'hFFFF_FFFF);
    rchk("mr2", OFS_MR2, 32'h0000_1FFF);
    wreg(OFS_STAT, 32'hFFFF_FFFF);
    rchk("stat", OFS_STAT, 32'h0000_1000);
    cmd(4'b0011, 3'd3, 13'h1ABC);
    cmd(4'b0011, 3'd5, 13'h0123);
    rchk("open", OFS_STAT, 32'h0000_1028);
    rd(3'd3, 13'h1ABC, 3'd5, 1'b0, 1'b0, 5);
    cmd(4'b0000, 3'd0, 13'h0048);
    cmd(4'b0000, 3'd1, 13'h0008);
    rchk("mr0 pin", OFS_MR0, 32'h0000_0048);
    wr(3'd5, 13'h0123, 3'd2, 1'b1, 7);
    rd(3'd5, 13'h0123, 3'd2, 1'b1, 1'b1, 7);
    rd(3'd3, 13'h1ABC, 3'd6, 1'b0, 1'b1, 7);
    cmd(4'b0000, 3'd1, 13'h0010);
    rd(3'd3, 13'h1ABC, 3'd1, 1'b0, 1'b1, 6);
    frz(3'd3, 13'h1ABC, 3'd4, 6);
    cmd(4'b1101, 3'd3, 13'h0000);
    quiet();
    cmd(4'b0101, 3'd0, 13'h1000);
    quiet();
    rchk("refused", OFS_STAT, 32'h0000_1828);
    wreg(OFS_STAT, 32'h0000_0800);
    cmd(4'b0010, 3'd5, 13'h0000);
    rchk("pre one", OFS_STAT, 32'h0000_1008);
    cmd(4'b0010, 3'd0, 13'h0400);
    rchk("pre all", OFS_STAT, 32'h0000_1000);
    cmd(4'b0001, 3'd0, 13'h0000);
    rchk("refresh", OFS_STAT, 32'h0001_1000);
    gate(4'hF, 16'h0100);
    gate(4'b0001, 16'h0300);
    summarize();
  end
endmodule // ddrca_front_tb
